/* rtl/pin_mux_pkg.sv */
// Register map, field layout and mode codes of the pin mux block
package pin_mux_pkg;

    localparam int ADDR_W = 16;

    // Register indices; byte address is four times the index
    localparam logic [15:0] BUS_SEL_IDX = 16'h1c00;
    localparam logic [15:0] SLEW_IDX = 16'h1c16;
    localparam logic [15:0] PULL_ONE_IDX = 16'h1c17;
    localparam logic [15:0] PULL_TWO_IDX = 16'h1c18;
    localparam logic [15:0] PULL_THREE_IDX = 16'h1c19;

    // Bus selection fields
    localparam int SP1_MODE_LSB = 10;
    localparam int PP_MODE_LSB = 12;
    localparam logic [15:0] BUS_SEL_MASK = 16'h7c00;

    // Output slew select fields, 1 = slow
    localparam int SLEW_CLOCK_OUTPUT_PIN_BIT = 0;
    localparam int SLEW_EXTERNAL_MEMORY_INTERFACE_BIT = 1;
    localparam logic [15:0] SLEW_MASK = 16'h0003;

    // Pull inhibit fields
    localparam int PULL_SP1_LSB = 6;
    localparam int PULL_GPIO12_LSB = 2;
    localparam int PULL_SHARED_LSB = 8;

    // Reset values
    localparam logic [15:0] BUS_SEL_RST = 16'h0000;
    localparam logic [15:0] SLEW_RST = 16'h0000;
    localparam logic [15:0] PULL_RST = 16'h0000;

    // Parallel port mode codes
    localparam logic [2:0] PP_OFF = 3'h0;
    localparam logic [2:0] PP_SPI_GP = 3'h1;
    localparam logic [2:0] PP_GPIO = 3'h2;
    localparam logic [2:0] PP_SPI_I2S3 = 3'h3;
    localparam logic [2:0] PP_I2S2_UART = 3'h4;
    localparam logic [2:0] PP_SPI_UART = 3'h5;
    localparam logic [2:0] PP_I2S_I2S = 3'h6;

    // Serial port one mode codes
    localparam logic [1:0] SP1_CARD = 2'h0;
    localparam logic [1:0] SP1_I2S = 2'h1;
    localparam logic [1:0] SP1_GPIO = 2'h2;

    // Source of a group of four shared pins
    typedef enum logic [2:0] {
        SRC_NONE,
        SRC_I2S2,
        SRC_I2S3,
        SRC_SPI,
        SRC_UART,
        SRC_GPIO
    } quad_src_t;

endpackage

/* rtl/pin_mux_ctrl.sv */
// Pin multiplexing, pull inhibit and slew control with an APB register slave
//
// Contract
// RULE_01: Every internal pull is separately switchable via three pull inhibit registers; the test reset pulldown here follows coreSupplyOn only.
// RULE_02: Software disables internal pulls where external pulls or drivers exist.
// RULE_03: With core supply down, all pulls off and bus holders on.
// RULE_04: Slew register picks fast or slow edges for clock out and memory pins.
// RULE_05: Only the bus selection register steers functions onto muxed pins.
// RULE_06: Software resets affected peripherals after any pin mux change.
// RULE_07: Parallel mode resets to unsupported zero; software sets 001 to 110.
// RULE_08: Mode 001: dedicated SPI and GPIO12-17 on, I2S2 low, UART high.
// RULE_09: Mode 010: dedicated pins idle, GPIO 18-20 and 27-31 on shared pins.
// RULE_10: Mode 011: SPI on low four shared pins, I2S3 on high four.
// RULE_11: Mode 100: I2S2 low four, UART high four, dedicated pins idle.
// RULE_12: Mode 101: SPI low four, UART high four, dedicated pins idle.
// RULE_13: Mode 110: dedicated SPI and GPIO12-17 on, I2S2 low, I2S3 high.
// RULE_14: Third pull register holds bits for GPIO12-17 and the eight shared pins.
// RULE_15: Serial port one mode resets to 00, card port on all six pins.
// RULE_16: Serial port one mode 01: I2S1 on four pins, GPIO10-11 on last two.
// RULE_17: Serial port one mode 10: GPIO6-11 on the six pins in order.
// RULE_18: First pull register holds one bit per serial port one pin.
// RULE_19: Serial port one functions come only from its mode field.
// RULE_20: Serial port one mode sits at bits 11:10; code 11 reserved.
// RULE_21: Inhibit bit one disables the pull; zero leaves it enabled.
// RULE_22: Parallel modes 000 and 111 drive nothing onto the muxed pins.
`timescale 1ns/10ps
module pin_mux_ctrl
    import pin_mux_pkg::*;
(
    input wire logic core_clk, // 200 MHz clock
    input wire logic rst, // Async reset, active high
    input wire logic psel, // APB select
    input wire logic penable, // APB access phase
    input wire logic pwrite, // APB write
    input wire logic [ADDR_W-1:0] paddr, // APB byte address
    input wire logic [31:0] pwdata, // APB write data
    output logic [31:0] prdata, // APB read data
    output logic pready, // APB ready
    output logic pslverr, // APB error on unmapped address
    input wire logic coreSupplyOn, // Core supply powered
    output logic busHoldEn, // Pad bus holders enabled
    output logic trstPullEn, // Test reset pulldown enable
    output logic [15:0] pullEnOne, // Pull enables, first group
    output logic [15:0] pullEnTwo, // Pull enables, second group
    output logic [15:0] pullEnThree, // Pull enables, third group
    output logic clockOutSlewSlow, // Clock output pin slow slew
    output logic memIfSlewSlow, // Memory interface pins slow slew
    input wire logic [7:0] ppPadIn, // Shared parallel pins, pad level
    output logic [7:0] ppPadOut, // Shared parallel pins, drive value
    output logic [7:0] ppPadOe, // Shared parallel pins, drive enable
    input wire logic [6:0] spiPadIn, // Dedicated SPI pins: clk, rx, tx, cs0-3
    output logic [6:0] spiPadOut, // Dedicated SPI pins, drive value
    output logic [6:0] spiPadOe, // Dedicated SPI pins, drive enable
    input wire logic [5:0] gpLoPadIn, // GPIO 12-17 pins, pad level
    output logic [5:0] gpLoPadOut, // GPIO 12-17 pins, drive value
    output logic [5:0] gpLoPadOe, // GPIO 12-17 pins, drive enable
    input wire logic [5:0] sp1PadIn, // Serial port one pins, pad level
    output logic [5:0] sp1PadOut, // Serial port one pins, drive value
    output logic [5:0] sp1PadOe, // Serial port one pins, drive enable
    input wire logic spiClkOut, // SPI clock from controller
    input wire logic spiTxOut, // SPI transmit data
    input wire logic [3:0] spiCsOut, // SPI chip selects
    input wire logic spiOutEn, // SPI drives its outputs
    output logic spiRxIn, // SPI receive data to controller
    input wire logic [3:0] i2s2Out, // I2S2 clk, fs, rx, dx drive values
    input wire logic [3:0] i2s2Oe, // I2S2 drive enables
    output logic [3:0] i2s2In, // I2S2 pad levels to port
    input wire logic [3:0] i2s3Out, // I2S3 clk, fs, rx, dx drive values
    input wire logic [3:0] i2s3Oe, // I2S3 drive enables
    output logic [3:0] i2s3In, // I2S3 pad levels to port
    input wire logic [3:0] uartOut, // UART rts, cts, rxd, txd drive values
    input wire logic [3:0] uartOe, // UART drive enables
    output logic [3:0] uartIn, // UART pad levels to port
    input wire logic [7:0] gpPpOut, // GPIO 18-20, 27-31 drive values
    input wire logic [7:0] gpPpOe, // GPIO 18-20, 27-31 drive enables
    output logic [7:0] gpPpIn, // GPIO 18-20, 27-31 pad levels
    input wire logic [5:0] gpLoOut, // GPIO 12-17 drive values
    input wire logic [5:0] gpLoOe, // GPIO 12-17 drive enables
    output logic [5:0] gpLoIn, // GPIO 12-17 pad levels
    input wire logic [5:0] cardOut, // Card port clk, cmd, d0-d3 values
    input wire logic [5:0] cardOe, // Card port drive enables
    output logic [5:0] cardIn, // Card port pad levels
    input wire logic [3:0] i2s1Out, // I2S1 clk, fs, dx, rx drive values
    input wire logic [3:0] i2s1Oe, // I2S1 drive enables
    output logic [3:0] i2s1In, // I2S1 pad levels
    input wire logic [5:0] gpSp1Out, // GPIO 6-11 drive values
    input wire logic [5:0] gpSp1Oe, // GPIO 6-11 drive enables
    output logic [5:0] gpSp1In // GPIO 6-11 pad levels
);

    ////////////////////////////////////////////////////////////////////////
    // Register file

    function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        return {idx[ADDR_W-3:0], 2'b00};
    endfunction

    logic [15:0] busSel_q;
    logic [15:0] slew_q;
    logic [15:0] pullOne_q;
    logic [15:0] pullTwo_q;
    logic [15:0] pullThree_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic [15:0] rdData;
    logic hit;
    logic wrEn;
    logic [2:0] parallel_port_mode;
    logic [1:0] serial_port_one_mode;

    assign parallel_port_mode = busSel_q[PP_MODE_LSB +: 3];
    assign serial_port_one_mode = busSel_q[SP1_MODE_LSB +: 2];
    assign wrEn = psel && penable && pready_q && pwrite && hit;

    always_comb begin
        hit = 1'b1;
        rdData = 16'h0000;
        if (paddr == byte_addr(BUS_SEL_IDX)) begin
            rdData = busSel_q;
        end else if (paddr == byte_addr(SLEW_IDX)) begin
            rdData = slew_q;
        end else if (paddr == byte_addr(PULL_ONE_IDX)) begin
            rdData = pullOne_q;
        end else if (paddr == byte_addr(PULL_TWO_IDX)) begin
            rdData = pullTwo_q;
        end else if (paddr == byte_addr(PULL_THREE_IDX)) begin
            rdData = pullThree_q;
        end else begin
            hit = 1'b0;
        end
    end

    // One wait state, answer on the second access cycle
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pready_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else begin
            pready_q <= psel && penable && !pready_q;
            if (psel && penable && !pready_q) begin
                prdata_q <= (!pwrite && hit) ? {16'h0000, rdData} : 32'h0000_0000;
                pslverr_q <= !hit;
            end
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            busSel_q <= BUS_SEL_RST; // RULE_07 RULE_15
        end else if (wrEn && paddr == byte_addr(BUS_SEL_IDX)) begin
            busSel_q <= pwdata[15:0] & BUS_SEL_MASK; // RULE_05 RULE_20
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            slew_q <= SLEW_RST;
        end else if (wrEn && paddr == byte_addr(SLEW_IDX)) begin
            slew_q <= pwdata[15:0] & SLEW_MASK; // RULE_04
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pullOne_q <= PULL_RST;
            pullTwo_q <= PULL_RST;
            pullThree_q <= PULL_RST;
        end else if (wrEn) begin
            if (paddr == byte_addr(PULL_ONE_IDX)) begin
                pullOne_q <= pwdata[15:0]; // RULE_01 RULE_18
            end
            if (paddr == byte_addr(PULL_TWO_IDX)) begin
                pullTwo_q <= pwdata[15:0]; // RULE_01
            end
            if (paddr == byte_addr(PULL_THREE_IDX)) begin
                pullThree_q <= pwdata[15:0]; // RULE_01 RULE_14
            end
        end
    end

    assign pready = pready_q;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    ////////////////////////////////////////////////////////////////////////
    // Pad control: pulls, bus holders, slew

    logic [15:0] pullEnOne_q;
    logic [15:0] pullEnTwo_q;
    logic [15:0] pullEnThree_q;
    logic busHold_q;
    logic trstPull_q;
    logic clkSlew_q;
    logic memSlew_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pullEnOne_q <= 16'h0000;
            pullEnTwo_q <= 16'h0000;
            pullEnThree_q <= 16'h0000;
            busHold_q <= 1'b0;
            trstPull_q <= 1'b0;
        end else begin
            pullEnOne_q <= coreSupplyOn ? ~pullOne_q : 16'h0000; // RULE_21 RULE_03
            pullEnTwo_q <= coreSupplyOn ? ~pullTwo_q : 16'h0000; // RULE_21 RULE_03
            pullEnThree_q <= coreSupplyOn ? ~pullThree_q : 16'h0000; // RULE_21 RULE_03
            busHold_q <= !coreSupplyOn; // RULE_03
            trstPull_q <= coreSupplyOn; // RULE_01
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            clkSlew_q <= 1'b0;
            memSlew_q <= 1'b0;
        end else begin
            clkSlew_q <= slew_q[SLEW_CLOCK_OUTPUT_PIN_BIT]; // RULE_04
            memSlew_q <= slew_q[SLEW_EXTERNAL_MEMORY_INTERFACE_BIT]; // RULE_04
        end
    end

    assign pullEnOne = pullEnOne_q;
    assign pullEnTwo = pullEnTwo_q;
    assign pullEnThree = pullEnThree_q;
    assign busHoldEn = busHold_q;
    assign trstPullEn = trstPull_q;
    assign clockOutSlewSlow = clkSlew_q;
    assign memIfSlewSlow = memSlew_q;

    ////////////////////////////////////////////////////////////////////////
    // Parallel port routing

    quad_src_t loSrc;
    quad_src_t hiSrc;
    logic dedOn;
    logic [3:0] spiQuadOut;
    logic [3:0] spiQuadOe;

    // Shared pin order: clk, cs0, rx, tx
    assign spiQuadOut = {spiTxOut, 1'b0, spiCsOut[0], spiClkOut};
    assign spiQuadOe = {spiOutEn, 1'b0, spiOutEn, spiOutEn};

    always_comb begin
        loSrc = SRC_NONE;
        hiSrc = SRC_NONE;
        dedOn = 1'b0;
        case (parallel_port_mode)
            PP_SPI_GP: begin
                dedOn = 1'b1; // RULE_08
                loSrc = SRC_I2S2;
                hiSrc = SRC_UART;
            end
            PP_GPIO: begin
                loSrc = SRC_GPIO; // RULE_09
                hiSrc = SRC_GPIO;
            end
            PP_SPI_I2S3: begin
                loSrc = SRC_SPI; // RULE_10
                hiSrc = SRC_I2S3;
            end
            PP_I2S2_UART: begin
                loSrc = SRC_I2S2; // RULE_11
                hiSrc = SRC_UART;
            end
            PP_SPI_UART: begin
                loSrc = SRC_SPI; // RULE_12
                hiSrc = SRC_UART;
            end
            PP_I2S_I2S: begin
                dedOn = 1'b1; // RULE_13
                loSrc = SRC_I2S2;
                hiSrc = SRC_I2S3;
            end
            default: begin
                dedOn = 1'b0; // RULE_22 RULE_07
            end
        endcase
    end

    function automatic logic [3:0] quad_drive(input quad_src_t src, input logic [3:0] i2s2,
            input logic [3:0] i2s3, input logic [3:0] spi, input logic [3:0] uart,
            input logic [3:0] gp);
        logic [3:0] res;
        res = 4'h0;
        case (src)
            SRC_I2S2: res = i2s2;
            SRC_I2S3: res = i2s3;
            SRC_SPI: res = spi;
            SRC_UART: res = uart;
            SRC_GPIO: res = gp;
            default: res = 4'h0;
        endcase
        return res;
    endfunction

    logic [7:0] ppOut_d;
    logic [7:0] ppOe_d;
    logic [7:0] ppPadOut_q;
    logic [7:0] ppPadOe_q;
    logic [6:0] spiPadOut_q;
    logic [6:0] spiPadOe_q;
    logic [5:0] gpLoPadOut_q;
    logic [5:0] gpLoPadOe_q;

    always_comb begin
        ppOut_d[3:0] = quad_drive(loSrc, i2s2Out, i2s3Out, spiQuadOut, uartOut,
            gpPpOut[3:0]);
        ppOut_d[7:4] = quad_drive(hiSrc, i2s2Out, i2s3Out, spiQuadOut, uartOut,
            gpPpOut[7:4]);
        ppOe_d[3:0] = quad_drive(loSrc, i2s2Oe, i2s3Oe, spiQuadOe, uartOe,
            gpPpOe[3:0]);
        ppOe_d[7:4] = quad_drive(hiSrc, i2s2Oe, i2s3Oe, spiQuadOe, uartOe,
            gpPpOe[7:4]);
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ppPadOut_q <= 8'h00;
            ppPadOe_q <= 8'h00;
        end else begin
            ppPadOut_q <= ppOut_d; // RULE_05
            ppPadOe_q <= ppOe_d; // RULE_22
        end
    end

    // Dedicated SPI pad order: clk, rx, tx, cs0-3
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            spiPadOut_q <= 7'h00;
            spiPadOe_q <= 7'h00;
            gpLoPadOut_q <= 6'h00;
            gpLoPadOe_q <= 6'h00;
        end else begin
            spiPadOut_q <= dedOn ? {spiCsOut, spiTxOut, 1'b0, spiClkOut} : 7'h00;
            spiPadOe_q <= dedOn ? {{5{spiOutEn}}, 1'b0, spiOutEn} : 7'h00; // RULE_08 RULE_13
            gpLoPadOut_q <= dedOn ? gpLoOut : 6'h00;
            gpLoPadOe_q <= dedOn ? gpLoOe : 6'h00; // RULE_08 RULE_13
        end
    end

    assign ppPadOut = ppPadOut_q;
    assign ppPadOe = ppPadOe_q;
    assign spiPadOut = spiPadOut_q;
    assign spiPadOe = spiPadOe_q;
    assign gpLoPadOut = gpLoPadOut_q;
    assign gpLoPadOe = gpLoPadOe_q;

    // Pad levels back to the peripherals, zero when not routed
    logic spiRx_q;
    logic [3:0] i2s2In_q;
    logic [3:0] i2s3In_q;
    logic [3:0] uartIn_q;
    logic [7:0] gpPpIn_q;
    logic [5:0] gpLoIn_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            spiRx_q <= 1'b0;
            i2s2In_q <= 4'h0;
            i2s3In_q <= 4'h0;
            uartIn_q <= 4'h0;
            gpPpIn_q <= 8'h00;
            gpLoIn_q <= 6'h00;
        end else begin
            spiRx_q <= dedOn ? spiPadIn[1] : ((loSrc == SRC_SPI) && ppPadIn[2]);
            i2s2In_q <= (loSrc == SRC_I2S2) ? ppPadIn[3:0] : 4'h0;
            i2s3In_q <= (hiSrc == SRC_I2S3) ? ppPadIn[7:4] : 4'h0;
            uartIn_q <= (hiSrc == SRC_UART) ? ppPadIn[7:4] : 4'h0;
            gpPpIn_q <= (loSrc == SRC_GPIO) ? ppPadIn : 8'h00; // RULE_09
            gpLoIn_q <= dedOn ? gpLoPadIn : 6'h00;
        end
    end

    assign spiRxIn = spiRx_q;
    assign i2s2In = i2s2In_q;
    assign i2s3In = i2s3In_q;
    assign uartIn = uartIn_q;
    assign gpPpIn = gpPpIn_q;
    assign gpLoIn = gpLoIn_q;

    ////////////////////////////////////////////////////////////////////////
    // Serial port one routing

    logic [5:0] sp1Out_d;
    logic [5:0] sp1Oe_d;
    logic [5:0] sp1PadOut_q;
    logic [5:0] sp1PadOe_q;
    logic [5:0] cardIn_q;
    logic [3:0] i2s1In_q;
    logic [5:0] gpSp1In_q;

    always_comb begin
        sp1Out_d = 6'h00;
        sp1Oe_d = 6'h00;
        case (serial_port_one_mode) // RULE_19
            SP1_CARD: begin
                sp1Out_d = cardOut; // RULE_15
                sp1Oe_d = cardOe;
            end
            SP1_I2S: begin
                sp1Out_d = {gpSp1Out[5:4], i2s1Out}; // RULE_16
                sp1Oe_d = {gpSp1Oe[5:4], i2s1Oe};
            end
            SP1_GPIO: begin
                sp1Out_d = gpSp1Out; // RULE_17
                sp1Oe_d = gpSp1Oe;
            end
            default: begin
                sp1Oe_d = 6'h00; // RULE_20
            end
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sp1PadOut_q <= 6'h00;
            sp1PadOe_q <= 6'h00;
            cardIn_q <= 6'h00;
            i2s1In_q <= 4'h0;
            gpSp1In_q <= 6'h00;
        end else begin
            sp1PadOut_q <= sp1Out_d;
            sp1PadOe_q <= sp1Oe_d;
            cardIn_q <= (serial_port_one_mode == SP1_CARD) ? sp1PadIn : 6'h00;
            i2s1In_q <= (serial_port_one_mode == SP1_I2S) ? sp1PadIn[3:0] : 4'h0;
            gpSp1In_q <= (serial_port_one_mode == SP1_GPIO) ? sp1PadIn :
                ((serial_port_one_mode == SP1_I2S) ? {sp1PadIn[5:4], 4'h0} : 6'h00);
        end
    end

    assign sp1PadOut = sp1PadOut_q;
    assign sp1PadOe = sp1PadOe_q;
    assign cardIn = cardIn_q;
    assign i2s1In = i2s1In_q;
    assign gpSp1In = gpSp1In_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions

    // Checks wait one edge past reset
    logic armed_q;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            armed_q <= 1'b0;
        end else begin
            armed_q <= 1'b1;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst || !armed_q);

    a_mode_off_quiet: assert property ( // RULE_22
        (parallel_port_mode == PP_OFF || parallel_port_mode == 3'h7) |=> (ppPadOe == 8'h00 && spiPadOe == 7'h00))
        else $error("muxed pins driven in an unused parallel mode");

    a_pull_forced_off: assert property ( // RULE_03
        !coreSupplyOn |=> (pullEnOne == 16'h0000 && pullEnThree == 16'h0000 && busHoldEn))
        else $error("pulls active or holders off with core supply down");

    a_pull_follows_inhibit: assert property ( // RULE_21
        coreSupplyOn |=> pullEnThree == ~$past(pullThree_q))
        else $error("pull enable does not follow the inhibit bits");

    a_gpio_mode_route: assert property ( // RULE_09
        parallel_port_mode == PP_GPIO |=> (ppPadOut == $past(gpPpOut) && gpLoPadOe == 6'h00))
        else $error("parallel GPIO mode routed wrongly");

    a_uart_high_route: assert property ( // RULE_11
        parallel_port_mode == PP_I2S2_UART |=> (ppPadOe == {$past(uartOe), $past(i2s2Oe)}))
        else $error("I2S2 and UART not on the shared pins");

    a_card_mode_route: assert property ( // RULE_15
        serial_port_one_mode == SP1_CARD |=> (sp1PadOut == $past(cardOut) && sp1PadOe == $past(cardOe)))
        else $error("card port not on serial port one pins");

    a_sp1_gpio_route: assert property ( // RULE_17
        serial_port_one_mode == SP1_GPIO |=> sp1PadOut == $past(gpSp1Out))
        else $error("GPIO 6-11 not on serial port one pins");

    a_mode_write_takes: assert property ( // RULE_05
        (wrEn && paddr == byte_addr(BUS_SEL_IDX)) |=> ##1
        (ppPadOut == $past(ppOut_d) && parallel_port_mode == $past(pwdata[14:12], 2)))
        else $error("bus selection write did not steer the pins");

    a_slew_write_takes: assert property ( // RULE_04
        (wrEn && paddr == byte_addr(SLEW_IDX)) |=> ##1
        memIfSlewSlow == $past(pwdata[SLEW_EXTERNAL_MEMORY_INTERFACE_BIT], 2))
        else $error("slew select write not reflected");

endmodule

/* bench/pin_board_model.sv */
// Board-side pin model: external drivers resolved against the block's pad drive
`timescale 1ns/10ps
module pin_board_model #(
    parameter logic [7:0] PP_LVL = 8'hd2,
    parameter logic [6:0] SPI_LVL = 7'h2b,
    parameter logic [5:0] GPLO_LVL = 6'h2d,
    parameter logic [5:0] SP1_LVL = 6'h1b
) (
    input wire logic [7:0] ppPadOut, // Shared pins, block value
    input wire logic [7:0] ppPadOe, // Shared pins, block enable
    input wire logic [6:0] spiPadOut, // SPI pins, block value
    input wire logic [6:0] spiPadOe, // SPI pins, block enable
    input wire logic [5:0] gpLoPadOut, // GPIO 12-17 pins, block value
    input wire logic [5:0] gpLoPadOe, // GPIO 12-17 pins, block enable
    input wire logic [5:0] sp1PadOut, // Serial port one pins, block value
    input wire logic [5:0] sp1PadOe, // Serial port one pins, block enable
    output logic [7:0] ppPadIn, // Shared pin levels
    output logic [6:0] spiPadIn, // SPI pin levels
    output logic [5:0] gpLoPadIn, // GPIO 12-17 pin levels
    output logic [5:0] sp1PadIn // Serial port one pin levels
);
    // A pin the block drives shows its value, else the board's driver
    assign ppPadIn = (ppPadOe & ppPadOut) | (~ppPadOe & PP_LVL);
    assign spiPadIn = (spiPadOe & spiPadOut) | (~spiPadOe & SPI_LVL);
    assign gpLoPadIn = (gpLoPadOe & gpLoPadOut) | (~gpLoPadOe & GPLO_LVL);
    assign sp1PadIn = (sp1PadOe & sp1PadOut) | (~sp1PadOe & SP1_LVL);
endmodule

/* bench/pin_mux_and_pull_control_bench.sv */
// Self-checking bench for the pin mux and pull control block
`timescale 1ns/10ps
module pin_mux_and_pull_control_bench import pin_mux_pkg::*;;
localparam logic [7:0] PPL = 8'hd2;
localparam logic [6:0] SPL = 7'h2b;
localparam logic [5:0] GLL = 6'h2d;
localparam logic [5:0] SP1L = 6'h1b;
localparam logic [15:0] REGS [4] = '{SLEW_IDX, PULL_ONE_IDX, PULL_TWO_IDX, PULL_THREE_IDX};
logic core_clk, rst, psel, penable, pwrite, coreSupplyOn, oe, pready, pslverr, err;
logic busHoldEn, trstPullEn, clockOutSlewSlow, memIfSlewSlow, spiRxIn;
logic [ADDR_W-1:0] paddr;
logic [31:0] pwdata, prdata, rdat, pat;
logic [15:0] pullEnOne, pullEnTwo, pullEnThree;
logic [7:0] ppPadIn, ppPadOut, ppPadOe, gpPpIn;
logic [6:0] spiPadIn, spiPadOut, spiPadOe;
logic [5:0] gpLoPadIn, gpLoPadOut, gpLoPadOe, sp1PadIn, sp1PadOut, sp1PadOe, gpLoIn;
logic [5:0] cardIn, gpSp1In;
logic [3:0] i2s2In, i2s3In, uartIn, i2s1In;
int badCount, numChecks, cyc;
pin_mux_ctrl i_dut (.core_clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .coreSupplyOn, .busHoldEn, .trstPullEn, .pullEnOne, .pullEnTwo, .pullEnThree,
    .clockOutSlewSlow, .memIfSlewSlow, .ppPadIn, .ppPadOut, .ppPadOe, .spiPadIn, .spiPadOut,
    .spiPadOe, .gpLoPadIn, .gpLoPadOut, .gpLoPadOe, .sp1PadIn, .sp1PadOut, .sp1PadOe,
    .spiClkOut(pat[0]), .spiTxOut(pat[1]), .spiCsOut(pat[5:2]), .spiOutEn(oe), .spiRxIn,
    .i2s2Out(pat[9:6]), .i2s2Oe({4{oe}}), .i2s2In, .i2s3Out(pat[13:10]), .i2s3Oe({4{oe}}),
    .i2s3In, .uartOut(pat[17:14]), .uartOe({4{oe}}), .uartIn, .gpPpOut(pat[25:18]),
    .gpPpOe({8{oe}}), .gpPpIn, .gpLoOut(pat[31:26]), .gpLoOe({6{oe}}), .gpLoIn,
    .cardOut(pat[5:0]), .cardOe({6{oe}}), .cardIn, .i2s1Out(pat[9:6]), .i2s1Oe({4{oe}}),
    .i2s1In, .gpSp1Out(pat[15:10]), .gpSp1Oe({6{oe}}), .gpSp1In);
pin_board_model #(.PP_LVL(PPL), .SPI_LVL(SPL), .GPLO_LVL(GLL), .SP1_LVL(SP1L)) i_board (
    .ppPadOut, .ppPadOe, .spiPadOut, .spiPadOe, .gpLoPadOut, .gpLoPadOe, .sp1PadOut,
    .sp1PadOe, .ppPadIn, .spiPadIn, .gpLoPadIn, .sp1PadIn);
////////////////////////////////////////////////////////////////////////////////
task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    numChecks++;
    if (got !== exp) begin
        badCount++;
        $display("FAIL at %0t: got %h expected %h", $time, got, exp);
    end
endtask
// One APB transfer; holds the request until pready is seen high
task automatic apb(input logic w, input logic [15:0] idx, input logic [31:0] d);
    @(posedge core_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[13:0], 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rdat = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic rd(input logic [15:0] idx, input logic [31:0] exp);
    apb(1'b0, idx, 32'h0);
    chk(rdat, exp);
endtask
// Pads follow a register write one edge after it commits
task automatic settle;
    repeat (3) @(posedge core_clk);
    #1;
endtask
task automatic printVerdict;
    $display("Checks %0d mismatches %0d", numChecks, badCount);
    if (badCount == 0 && numChecks > 0) begin
        $display("Finished cleanly");
    end else begin
        $display("Finished with errors");
    end
    $finish;
endtask
////////////////////////////////////////////////////////////////////////////////
initial begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
end
always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
        badCount++;
        printVerdict;
    end
end
initial begin
    {psel, penable, pwrite, paddr, pwdata, oe} = '0;
    rst = 1'b1;
    coreSupplyOn = 1'b1;
    pat = 32'h5a3c96e1;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    settle;
    chk(pullEnTwo, 16'hffff);
    chk(ppPadOe, 8'h00);
    chk(cardIn, SP1L);
    rd(BUS_SEL_IDX, 32'h0);
    foreach (REGS[i]) begin
        rd(REGS[i], 32'h0);
        apb(1'b1, REGS[i], 32'h0000c3a5);
        rd(REGS[i], i == 0 ? 32'h1 : 32'hc3a5);
    end
    settle;
    chk({clockOutSlewSlow, memIfSlewSlow}, 2'b10);
    chk(pullEnOne, 16'h3c5a);
    chk(pullEnThree, 16'h3c5a);
    chk(trstPullEn, 1'b1);
    @(posedge core_clk);
    coreSupplyOn <= 1'b0;
    settle;
    chk({pullEnOne, pullEnThree}, 32'h0);
    chk({pullEnTwo, trstPullEn, busHoldEn}, 18'h1);
    @(posedge core_clk);
    coreSupplyOn <= 1'b1;
    settle;
    chk({pullEnTwo, busHoldEn}, 17'h78b4);
    $display("Registers and pulls done");
    for (int m = 0; m < 8; m++) begin
        apb(1'b1, BUS_SEL_IDX, {17'h0, m[2:0], 12'h0});
        settle;
        chk(i2s2In, (m inside {1, 4, 6}) ? PPL[3:0] : 4'h0);
        chk(uartIn, (m inside {1, 4, 5}) ? PPL[7:4] : 4'h0);
        chk(i2s3In, (m inside {3, 6}) ? PPL[7:4] : 4'h0);
        chk(gpPpIn, m == 2 ? PPL : 8'h0);
        chk(gpLoIn, (m inside {1, 6}) ? GLL : 6'h0);
        chk(spiRxIn, (m inside {3, 5}) ? PPL[2] : (m inside {1, 6}) ? SPL[1] : 1'b0);
        chk(cardIn, SP1L);
    end
    $display("Parallel port modes done");
    for (int s = 0; s < 4; s++) begin
        apb(1'b1, BUS_SEL_IDX, {17'h0, 3'h2, s[1:0], 10'h0});
        settle;
        chk(cardIn, s == 0 ? SP1L : 6'h0);
        chk(i2s1In, s == 1 ? SP1L[3:0] : 4'h0);
        chk(gpSp1In, s == 2 ? SP1L : s == 1 ? {SP1L[5:4], 4'h0} : 6'h0);
        chk(gpPpIn, PPL);
    end
    $display("Serial port one modes done");
    @(posedge core_clk);
    oe <= 1'b1;
    settle;
    chk({ppPadOe, ppPadOut}, {8'hff, pat[25:18]});
    chk(gpPpIn, pat[25:18]);
    chk(sp1PadOe, 6'h00);
    apb(1'b1, BUS_SEL_IDX, 32'h1000);
    settle;
    chk({spiPadOe, gpLoPadOe}, {7'h7d, 6'h3f});
    chk({spiPadOut, gpLoPadOut}, {pat[5:1], 1'b0, pat[0], pat[31:26]});
    chk(ppPadOut, {pat[17:14], pat[9:6]});
    chk(sp1PadOut, pat[5:0]);
    apb(1'b1, BUS_SEL_IDX, 32'h3000);
    settle;
    chk({ppPadOe, ppPadOut}, {8'hfb, pat[13:10], pat[1], 1'b0, pat[2], pat[0]});
    apb(1'b1, BUS_SEL_IDX, 32'hffff);
    rd(BUS_SEL_IDX, 32'h7c00);
    settle;
    chk({ppPadOe, spiPadOe, gpLoPadOe}, 21'h0);
    rd(16'h1c20, 32'h0);
    chk(err, 1'b1);
    $display("Pad drive and unmapped access done");
    printVerdict;
end
endmodule
